/* verilog/ddm_pkg.sv */
// Purpose: Shared constants, codes and carriers for the diagnostic output mux
// Assumes: All inputs are synchronous to clk
// Notes:   Select codes and channel codes are fixed by the hardware map
package ddm_pkg;

    // Source select layout
    localparam int SEL_W   = 7;
    localparam int GRP_MSB = 6;
    localparam int GRP_LSB = 4;
    localparam int CH_MSB  = 3;
    localparam int CH_LSB  = 0;
    localparam int ICON_W  = 3;

    // Output configuration codes
    typedef enum logic [1:0] {
        DDM_MODE_PINCTL  = 2'h0,
        DDM_MODE_DIGITAL = 2'h1,
        DDM_MODE_ICON    = 2'h3,
        DDM_MODE_ANALOG  = 2'h2
    } ddm_mode_e;

    // Channel groups
    localparam logic [2:0] GRP_SUPPLY = 3'h0;
    localparam logic [2:0] GRP_CLOCK  = 3'h1;
    localparam logic [2:0] GRP_PROT   = 3'h2;
    localparam logic [2:0] GRP_WARN   = 3'h3;

    // Supply monitor channels
    localparam logic [3:0] CH_INT_REG_UV = 4'h1;
    localparam logic [3:0] CH_BUCK_A_UV  = 4'h7;
    localparam logic [3:0] CH_BUCK_A_OV  = 4'h8;
    localparam logic [3:0] CH_BUCK_B_UV  = 4'h9;
    localparam logic [3:0] CH_BUCK_B_OV  = 4'ha;
    localparam logic [3:0] CH_BOOST_UV   = 4'hb;
    localparam logic [3:0] CH_BOOST_OV   = 4'hc;
    localparam logic [3:0] CH_IO_SUP_OV  = 4'hf;

    // Clock channels
    localparam logic [3:0] CH_SYNC_OUT    = 4'h0;
    localparam logic [3:0] CH_SYS_CLK_SRC = 4'h1;
    localparam logic [3:0] CH_PLL_CLK     = 4'h2;
    localparam logic [3:0] CH_SYNC_IN     = 4'h3;
    localparam logic [3:0] CH_SW_BUCK_A   = 4'h4;
    localparam logic [3:0] CH_SW_BUCK_B   = 4'h5;
    localparam logic [3:0] CH_SW_BOOST    = 4'h7;

    // Protection channels
    localparam logic [3:0] CH_BA_HS_ILIM   = 4'h1;
    localparam logic [3:0] CH_BA_LS_ILIM   = 4'h2;
    localparam logic [3:0] CH_BA_SINK_ILIM = 4'h3;
    localparam logic [3:0] CH_BA_OVP       = 4'h4;
    localparam logic [3:0] CH_BA_OT        = 4'h5;
    localparam logic [3:0] CH_BB_HS_ILIM   = 4'h6;
    localparam logic [3:0] CH_BB_LS_ILIM   = 4'h7;
    localparam logic [3:0] CH_BB_SINK_ILIM = 4'h8;
    localparam logic [3:0] CH_BB_OVP       = 4'h9;
    localparam logic [3:0] CH_BB_OT        = 4'ha;
    localparam logic [3:0] CH_BST_LS_ILIM  = 4'hb;
    localparam logic [3:0] CH_BST_HS_ILIM  = 4'hc;
    localparam logic [3:0] CH_BST_SINK_ILIM = 4'hd;
    localparam logic [3:0] CH_BST_OVP      = 4'he;
    localparam logic [3:0] CH_BST_OT       = 4'hf;

    // Warning channels
    localparam logic [3:0] CH_WARN_BUCK_A = 4'h1;
    localparam logic [3:0] CH_WARN_BUCK_B = 4'h2;
    localparam logic [3:0] CH_WARN_BOOST  = 4'h3;

    // Interconnect select codes
    localparam logic [2:0] ICON_MCU_ERR = 3'h0;
    localparam logic [2:0] ICON_NCS     = 3'h1;
    localparam logic [2:0] ICON_SDI     = 3'h2;
    localparam logic [2:0] ICON_SCK     = 3'h3;
    localparam logic [2:0] ICON_SDO     = 3'h7;

    // Reset values
    localparam logic PIN_RST = 1'b0;
    localparam logic OE_RST  = 1'b0;

    typedef struct packed {
        logic int_reg_uv;
        logic buck_a_uv;
        logic buck_a_ov;
        logic buck_b_uv;
        logic buck_b_ov;
        logic boost_uv;
        logic boost_ov;
        logic io_sup_ov;
    } ddm_supply_s;

    typedef struct packed {
        logic sync_out;
        logic sys_clk_src;
        logic pll_clk;
        logic sync_in;
        logic sw_buck_a;
        logic sw_buck_b;
        logic sw_boost;
    } ddm_clock_s;

    typedef struct packed {
        logic ba_hs_ilim;
        logic ba_ls_ilim;
        logic ba_sink_ilim;
        logic ba_ovp;
        logic ba_ot;
        logic bb_hs_ilim;
        logic bb_ls_ilim;
        logic bb_sink_ilim;
        logic bb_ovp;
        logic bb_ot;
        logic bst_ls_ilim;
        logic bst_hs_ilim;
        logic bst_sink_ilim;
        logic bst_ovp;
        logic bst_ot;
    } ddm_prot_s;

    typedef struct packed {
        logic buck_a;
        logic buck_b;
        logic boost;
    } ddm_warn_s;

    typedef struct packed {
        ddm_supply_s supply;
        ddm_clock_s  clock;
        ddm_prot_s   prot;
        ddm_warn_s   warn;
    } ddm_dsig_s;

    typedef struct packed {
        logic mcu_err;
        logic ncs;
        logic sdi;
        logic sck;
        logic sdo_in;
    } ddm_pins_s;

    typedef struct packed {
        logic [SEL_W-1:0]  diag_source_select;
        ddm_mode_e         output_config_field;
        logic              pin_level_bit;
        logic              output_enable_bit;
        logic [ICON_W-1:0] interconnect_select;
        logic              sdo_level_bit;
    } ddm_ctrl_s;

    function automatic logic [2:0] sel_group(input logic [SEL_W-1:0] sel);
        sel_group = sel[GRP_MSB:GRP_LSB];
    endfunction

    function automatic logic [3:0] sel_chan(input logic [SEL_W-1:0] sel);
        sel_chan = sel[CH_MSB:CH_LSB];
    endfunction

endpackage

/* verilog/ddm_dmux_decode.sv */
// Purpose: Decode group and channel into one internal digital source
// Assumes: Pure combinational, registered by the caller
// Notes:   Every unmapped code yields logic 0 and raises the reserved flag
`timescale 1ns/1ps
module ddm_dmux_decode (
    // Selection
    input  wire logic [ddm_pkg::SEL_W-1:0] sel,
    // Internal signals
    input  wire ddm_pkg::ddm_dsig_s        dsig,
    // Result
    output logic                           src,
    output logic                           reserved
);
    import ddm_pkg::*;

    logic [2:0] grp;
    logic [3:0] ch;

    always_comb begin
        grp      = sel_group(sel);
        ch       = sel_chan(sel);
        src      = 1'b0;
        reserved = 1'b0;
        case (grp)
            GRP_SUPPLY: begin
                case (ch)
                    CH_INT_REG_UV: src = dsig.supply.int_reg_uv;
                    CH_BUCK_A_UV:  src = dsig.supply.buck_a_uv;
                    CH_BUCK_A_OV:  src = dsig.supply.buck_a_ov;
                    CH_BUCK_B_UV:  src = dsig.supply.buck_b_uv;
                    CH_BUCK_B_OV:  src = dsig.supply.buck_b_ov;
                    CH_BOOST_UV:   src = dsig.supply.boost_uv;
                    CH_BOOST_OV:   src = dsig.supply.boost_ov;
                    CH_IO_SUP_OV:  src = dsig.supply.io_sup_ov;
                    default:       reserved = 1'b1;
                endcase
            end
            GRP_CLOCK: begin
                case (ch)
                    CH_SYNC_OUT:    src = dsig.clock.sync_out;
                    CH_SYS_CLK_SRC: src = dsig.clock.sys_clk_src;
                    CH_PLL_CLK:     src = dsig.clock.pll_clk;
                    CH_SYNC_IN:     src = dsig.clock.sync_in;
                    CH_SW_BUCK_A:   src = dsig.clock.sw_buck_a;
                    CH_SW_BUCK_B:   src = dsig.clock.sw_buck_b;
                    CH_SW_BOOST:    src = dsig.clock.sw_boost;
                    default:        reserved = 1'b1;
                endcase
            end
            GRP_PROT: begin
                case (ch)
                    CH_BA_HS_ILIM:    src = dsig.prot.ba_hs_ilim;
                    CH_BA_LS_ILIM:    src = dsig.prot.ba_ls_ilim;
                    CH_BA_SINK_ILIM:  src = dsig.prot.ba_sink_ilim;
                    CH_BA_OVP:        src = dsig.prot.ba_ovp;
                    CH_BA_OT:         src = dsig.prot.ba_ot;
                    CH_BB_HS_ILIM:    src = dsig.prot.bb_hs_ilim;
                    CH_BB_LS_ILIM:    src = dsig.prot.bb_ls_ilim;
                    CH_BB_SINK_ILIM:  src = dsig.prot.bb_sink_ilim;
                    CH_BB_OVP:        src = dsig.prot.bb_ovp;
                    CH_BB_OT:         src = dsig.prot.bb_ot;
                    CH_BST_LS_ILIM:   src = dsig.prot.bst_ls_ilim;
                    CH_BST_HS_ILIM:   src = dsig.prot.bst_hs_ilim;
                    CH_BST_SINK_ILIM: src = dsig.prot.bst_sink_ilim;
                    CH_BST_OVP:       src = dsig.prot.bst_ovp;
                    CH_BST_OT:        src = dsig.prot.bst_ot;
                    default:          reserved = 1'b1;
                endcase
            end
            GRP_WARN: begin
                case (ch)
                    CH_WARN_BUCK_A: src = dsig.warn.buck_a;
                    CH_WARN_BUCK_B: src = dsig.warn.buck_b;
                    CH_WARN_BOOST:  src = dsig.warn.boost;
                    default:        reserved = 1'b1;
                endcase
            end
            default: reserved = 1'b1;
        endcase
    end

endmodule // ddm_dmux_decode

/* verilog/ddm_icon_route.sv */
// Purpose: Pick the interconnect pin looped back to the diagnostic pin
// Assumes: Pins are already synchronous to clk
// Notes:   Codes 100b to 110b are unmapped and give logic 0
`timescale 1ns/1ps
module ddm_icon_route (
    // Selection
    input  wire logic [ddm_pkg::ICON_W-1:0] icon_sel,
    // Sensed pins
    input  wire ddm_pkg::ddm_pins_s         pins,
    // Result
    output logic                            src,
    output logic                            sdo_sel
);
    import ddm_pkg::*;

    always_comb begin
        src     = 1'b0;
        sdo_sel = 1'b0;
        case (icon_sel)
            ICON_MCU_ERR: src = pins.mcu_err;
            ICON_NCS:     src = pins.ncs;
            ICON_SDI:     src = pins.sdi;
            ICON_SCK:     src = pins.sck;
            ICON_SDO: begin
                src     = pins.sdo_in;
                sdo_sel = 1'b1;
            end
            default:      src = 1'b0;
        endcase
    end

endmodule // ddm_icon_route

/* verilog/ddm_diag_mux.sv */
// Purpose: Diagnostic output pin multiplexer, digital side
// Assumes: Control fields held by the SPI register block, synchronous inputs
// Notes:   Every pin-facing output is registered, so a change lands one edge later
`timescale 1ns/1ps

//Contract
// - Decode group and channel; reserved codes give 0
// - Group 000b routes supply monitor comparators
// - Group 001b routes sync and PLL clocks
// - Group 001b code 0001b routes system clock
// - Group 001b routes switching clocks; 0110b zero
// - Groups 010b, 011b route protection and warnings
// - Sink current limits on 0011b, 1000b, 1101b
// - Overvoltage and overtemperature protection code placement
// - Mode 00b drives pin from level bit
// - Mode 11b loops a digital input pin
// - Interconnect select picks error, select, data, clock
// - Serial output buffer follows control bit D6
// - Serial pin input buffer shown on pin
// - Mode 01b digital, 10b analog buffer
// - Enable cleared puts pin in high impedance
module ddm_diag_mux (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               sys_rst,
    // Control fields
    input  wire ddm_pkg::ddm_ctrl_s ctrl,
    // Internal digital sources
    input  wire ddm_pkg::ddm_dsig_s dsig,
    // Sensed interconnect pins
    input  wire ddm_pkg::ddm_pins_s pins,
    // Serial data from the SPI engine
    input  wire logic               spi_sdo_data,
    input  wire logic               spi_sdo_oe,
    // Diagnostic output pin
    output logic                    diag_output_pin_o,
    output logic                    diag_output_pin_oe,
    // Serial data output pin
    output logic                    sdo_pad_o,
    output logic                    sdo_pad_oe,
    // Buffer enables and status
    output logic                    analog_buf_en,
    output logic                    sdo_check_active,
    output logic                    reserved_sel,
    output logic                    supply_cut
);
    import ddm_pkg::*;

    logic dmux_src;
    logic dmux_rsv;
    logic icon_src;
    logic icon_sdo;
    logic sdo_check;

    logic pin_r;
    logic pin_nxt;
    logic oe_r;
    logic oe_nxt;
    logic sdo_r;
    logic sdo_nxt;
    logic sdo_oe_r;
    logic sdo_oe_nxt;
    logic abuf_r;
    logic abuf_nxt;
    logic chk_r;
    logic chk_nxt;
    logic rsv_r;
    logic rsv_nxt;
    logic cut_r;
    logic cut_nxt;

    ddm_dmux_decode u_dmux (
        .sel      (ctrl.diag_source_select),
        .dsig     (dsig),
        .src      (dmux_src),
        .reserved (dmux_rsv)
    );

    ddm_icon_route u_icon (
        .icon_sel (ctrl.interconnect_select),
        .pins     (pins),
        .src      (icon_src),
        .sdo_sel  (icon_sdo)
    );

    // Output check only while the host keeps the select pin high
    assign sdo_check = (ctrl.output_config_field == DDM_MODE_ICON) && icon_sdo
                       && pins.ncs;

    always_comb begin
        pin_nxt    = 1'b0;
        oe_nxt     = 1'b0;
        abuf_nxt   = 1'b0;
        rsv_nxt    = 1'b0;
        chk_nxt    = sdo_check;
        cut_nxt    = dsig.supply.io_sup_ov;
        sdo_nxt    = spi_sdo_data;
        sdo_oe_nxt = spi_sdo_oe;
        if (sdo_check) begin
            sdo_nxt    = ctrl.sdo_level_bit;
            sdo_oe_nxt = 1'b1;
        end
        case (ctrl.output_config_field)
            DDM_MODE_PINCTL: begin
                pin_nxt = ctrl.pin_level_bit;
                oe_nxt  = 1'b1;
            end
            DDM_MODE_DIGITAL: begin
                pin_nxt = dmux_src;
                rsv_nxt = dmux_rsv;
                oe_nxt  = 1'b1;
            end
            DDM_MODE_ANALOG: begin
                abuf_nxt = 1'b1;
                oe_nxt   = 1'b0;
            end
            DDM_MODE_ICON: begin
                pin_nxt = icon_src;
                oe_nxt  = 1'b1;
            end
            default: begin
                pin_nxt = 1'b0;
                oe_nxt  = 1'b0;
            end
        endcase
        // Both buffers lose supply on an I/O overvoltage
        if (!ctrl.output_enable_bit || dsig.supply.io_sup_ov) begin
            oe_nxt   = 1'b0;
            abuf_nxt = 1'b0;
        end
        // Park the level low while undriven to avoid a stale value at re-enable
        if (!oe_nxt) begin
            pin_nxt = 1'b0;
        end
    end

    // Single register stage keeps the update latency fixed at one edge
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_r    <= PIN_RST;
            oe_r     <= OE_RST;
            sdo_r    <= PIN_RST;
            sdo_oe_r <= OE_RST;
            abuf_r   <= OE_RST;
            chk_r    <= 1'b0;
            rsv_r    <= 1'b0;
            cut_r    <= 1'b0;
        end else begin
            pin_r    <= pin_nxt;
            oe_r     <= oe_nxt;
            sdo_r    <= sdo_nxt;
            sdo_oe_r <= sdo_oe_nxt;
            abuf_r   <= abuf_nxt;
            chk_r    <= chk_nxt;
            rsv_r    <= rsv_nxt;
            cut_r    <= cut_nxt;
        end
    end

    assign diag_output_pin_o  = pin_r;
    assign diag_output_pin_oe = oe_r;
    assign sdo_pad_o          = sdo_r;
    assign sdo_pad_oe         = sdo_oe_r;
    assign analog_buf_en      = abuf_r;
    assign sdo_check_active   = chk_r;
    assign reserved_sel       = rsv_r;
    assign supply_cut         = cut_r;

endmodule // ddm_diag_mux

/* tb/ddm_diag_mux_asserts.sv */
// Purpose: Port-level checks of the diagnostic output mux
// Assumes: One clock domain, async active-high reset
// Notes:   Every output lands one edge after its cause
`timescale 1ns/1ps
module ddm_diag_mux_asserts
    import ddm_pkg::*;
(
    // Clock and reset
    input wire logic      clk,
    input wire logic      sys_rst,
    // Observed inputs
    input wire ddm_ctrl_s ctrl,
    input wire ddm_dsig_s dsig,
    input wire ddm_pins_s pins,
    // Observed outputs
    input wire logic      diag_output_pin_o,
    input wire logic      diag_output_pin_oe,
    input wire logic      sdo_pad_o,
    input wire logic      sdo_pad_oe,
    input wire logic      analog_buf_en,
    input wire logic      sdo_check_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic live;
    logic sdo_chk;
    assign live    = ctrl.output_enable_bit && !dsig.supply.io_sup_ov;
    assign sdo_chk = ctrl.output_config_field == DDM_MODE_ICON && ctrl.interconnect_select == 3'h7
                     && pins.ncs;

    AST_DISABLED: assert property (!live |=> !diag_output_pin_oe && !analog_buf_en)
        else $error("pin buffer still on while disabled");
    AST_PIN_LEVEL: assert property (ctrl.output_config_field == DDM_MODE_PINCTL && live
        |=> diag_output_pin_oe && diag_output_pin_o == $past(ctrl.pin_level_bit))
        else $error("pin control level wrong");
    AST_RESERVED_GROUP: assert property (ctrl.output_config_field == DDM_MODE_DIGITAL
        && ctrl.diag_source_select[6] |=> !diag_output_pin_o)
        else $error("reserved group not zero");
    AST_SYS_CLOCK: assert property (ctrl.output_config_field == DDM_MODE_DIGITAL && live
        && ctrl.diag_source_select == 7'h11 |=> diag_output_pin_o == $past(dsig.clock.sys_clk_src))
        else $error("system clock source not routed");
    AST_SINK_LIMIT: assert property (ctrl.output_config_field == DDM_MODE_DIGITAL && live
        && ctrl.diag_source_select == 7'h2d ##1 1'b1
        |-> diag_output_pin_o == $past(dsig.prot.bst_sink_ilim))
        else $error("sink limit flag not routed");
    AST_ANALOG: assert property (ctrl.output_config_field == DDM_MODE_ANALOG
        |=> !diag_output_pin_oe && analog_buf_en == $past(live))
        else $error("analog mode buffer state wrong");
    AST_SDO_DRIVE: assert property (sdo_chk
        |=> sdo_check_active && sdo_pad_oe && sdo_pad_o == $past(ctrl.sdo_level_bit))
        else $error("serial output buffer not under control bit");
    AST_SDO_SENSE: assert property (sdo_chk && live
        |=> diag_output_pin_oe && diag_output_pin_o == $past(pins.sdo_in))
        else $error("serial input buffer not shown");
    AST_SCK_LOOP: assert property (ctrl.output_config_field == DDM_MODE_ICON && live
        && ctrl.interconnect_select == 3'h3 |=> diag_output_pin_o == $past(pins.sck))
        else $error("clock pin not looped");
endmodule // ddm_diag_mux_asserts

/* tb/ddm_mcu_pin_model.sv */
// Purpose: Controller input pin watching the diagnostic pad
// Assumes: Pad has no pull resistor
// Notes:   Released pad reads as inverse of last driven level
`timescale 1ns/1ps
module ddm_mcu_pin_model (
    // Clock
    input  wire logic clk,
    // Pad drive from the device
    input  wire logic drv_level,
    input  wire logic drv_en,
    // Level seen by the controller
    output logic      level
);
    logic last_r = 1'b0;
    // Floating pad keeps no value, so never echo the old one
    assign level = drv_en ? drv_level : ~last_r;
    always_ff @(posedge clk) begin
        if (drv_en) begin
            last_r <= drv_level;
        end
    end
endmodule // ddm_mcu_pin_model

/* tb/ddm_diag_mux_tb.sv */
// Purpose: Self-checking bench of the diagnostic output mux
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Code sweeps first, then seeded random traffic
`timescale 1ns/1ps
module ddm_diag_mux_tb;
    import ddm_pkg::*;
    logic        clk;
    logic        sys_rst;
    ddm_ctrl_s   ctrl;
    ddm_dsig_s   dsig;
    ddm_pins_s   pins;
    logic        spi_sdo_data;
    logic        spi_sdo_oe;
    logic [7:0]  outs;
    logic        mcu_level;
    int          errors;
    int          num_checks;
    logic [15:0] lfsr_r = 16'h0010;

    ddm_diag_mux u_dut (.clk(clk), .sys_rst(sys_rst), .ctrl(ctrl), .dsig(dsig), .pins(pins),
        .spi_sdo_data(spi_sdo_data), .spi_sdo_oe(spi_sdo_oe), .diag_output_pin_o(outs[7]),
        .diag_output_pin_oe(outs[6]), .sdo_pad_o(outs[5]), .sdo_pad_oe(outs[4]),
        .analog_buf_en(outs[3]), .sdo_check_active(outs[2]), .reserved_sel(outs[1]),
        .supply_cut(outs[0]));
    ddm_mcu_pin_model u_mcu (.clk(clk), .drv_level(outs[7]), .drv_en(outs[6]), .level(mcu_level));

    function automatic logic [15:0] rnd();
        for (int i = 0; i < 16; i++) begin
            lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
        end
        return lfsr_r;
    endfunction

    function automatic logic exp_src(ddm_ctrl_s c, ddm_dsig_s d, ddm_pins_s p);
        logic [3:0] ch;
        ch = c.diag_source_select[3:0];
        if (c.output_config_field == DDM_MODE_PINCTL) return c.pin_level_bit;
        if (c.output_config_field == DDM_MODE_ICON) begin
            case (c.interconnect_select)
                3'h0: return p.mcu_err;
                3'h1: return p.ncs;
                3'h2: return p.sdi;
                3'h3: return p.sck;
                3'h7: return p.sdo_in;
                default: return 1'b0;
            endcase
        end
        if (c.output_config_field != DDM_MODE_DIGITAL) return 1'b0;
        case (c.diag_source_select[6:4])
            3'h0: return ch == 4'h1 ? d.supply[7] : ch == 4'hf ? d.supply[0]
                         : (ch >= 4'h7 && ch <= 4'hc) ? d.supply[13 - ch] : 1'b0;
            3'h1: return ch == 4'h7 ? d.clock[0] : ch < 4'h6 ? d.clock[6 - ch] : 1'b0;
            3'h2: return ch == 4'h0 ? 1'b0 : d.prot[15 - ch];
            3'h3: return (ch >= 4'h1 && ch <= 4'h3) ? d.warn[3 - ch] : 1'b0;
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic exp_rsv(logic [6:0] s);
        logic [3:0] c;
        c = s[3:0];
        case (s[6:4])
            3'h0: return !(c == 4'h1 || c == 4'hf || (c >= 4'h7 && c <= 4'hc));
            3'h1: return c == 4'h6 || c[3];
            3'h2: return c == 4'h0;
            3'h3: return c == 4'h0 || c > 4'h3;
            default: return 1'b1;
        endcase
    endfunction

    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic step();
        logic live;
        logic oe;
        logic src;
        logic sdo_chk;
        logic rsv;
        live = ctrl.output_enable_bit && !dsig.supply.io_sup_ov;
        rsv = ctrl.output_config_field == DDM_MODE_DIGITAL && exp_rsv(ctrl.diag_source_select);
        oe = live && ctrl.output_config_field != DDM_MODE_ANALOG;
        src = exp_src(ctrl, dsig, pins);
        sdo_chk = ctrl.output_config_field == DDM_MODE_ICON && ctrl.interconnect_select == 3'h7
                  && pins.ncs;
        @(posedge clk);
        #1;
        check("pin_oe", outs[6], oe);
        check("pin_level", outs[7], oe & src);
        check("mcu_level", oe ? mcu_level : 1'b0, oe & src);
        check("analog_buf", outs[3], live && ctrl.output_config_field == DDM_MODE_ANALOG);
        check("sdo_pad", outs[5:4], sdo_chk ? {ctrl.sdo_level_bit, 1'b1}
              : {spi_sdo_data, spi_sdo_oe});
        check("sdo_check", outs[2], sdo_chk);
        check("reserved_sel", outs[1], rsv);
        check("supply_cut", outs[0], dsig.supply.io_sup_ov);
    endtask

    task automatic stop_test();
        if (errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        #200000;
        errors++;
        stop_test();
    end

    initial begin
        logic [47:0] r;
        errors = 0;
        num_checks = 0;
        sys_rst = 1'b1;
        ctrl = '0;
        dsig = '0;
        pins = '0;
        spi_sdo_data = 1'b0;
        spi_sdo_oe = 1'b0;
        repeat (12) @(posedge clk);
        #1;
        check("reset_outs", outs, 8'h00);
        sys_rst = 1'b0;
        // Every group and channel, sources all high except io_sup_ov, then all low
        for (int k = 0; k < 256; k++) begin
            ctrl = '0;
            ctrl.output_config_field = DDM_MODE_DIGITAL;
            ctrl.output_enable_bit = 1'b1;
            ctrl.diag_source_select = k[6:0];
            dsig = k[7] ? '0 : '1;
            dsig.supply.io_sup_ov = 1'b0;
            step();
        end
        for (int k = 0; k < 16; k++) begin
            ctrl = '0;
            ctrl.output_config_field = DDM_MODE_ICON;
            ctrl.output_enable_bit = 1'b1;
            ctrl.interconnect_select = k[2:0];
            ctrl.sdo_level_bit = k[3];
            r = {rnd(), rnd(), rnd()};
            pins = r[4:0];
            pins.ncs = 1'b1;
            step();
        end
        for (int n = 0; n < 3000; n++) begin
            if (n == 1500) begin
                sys_rst = 1'b1;
                @(posedge clk);
                #1;
                check("reset_outs", outs, 8'h00);
                sys_rst = 1'b0;
            end
            r = {rnd(), rnd(), rnd()};
            dsig = r[32:0];
            // Supply fault kept rare so the pin is mostly driven
            dsig.supply.io_sup_ov = &r[47:45];
            r = {rnd(), rnd(), rnd()};
            ctrl = r[14:0];
            ctrl.output_enable_bit = |r[44:43];
            pins = r[20:16];
            {spi_sdo_data, spi_sdo_oe} = r[22:21];
            step();
        end
        stop_test();
    end
endmodule // ddm_diag_mux_tb

bind ddm_diag_mux ddm_diag_mux_asserts u_asserts (.clk(clk), .sys_rst(sys_rst), .ctrl(ctrl),
    .dsig(dsig), .pins(pins), .diag_output_pin_o(diag_output_pin_o),
    .diag_output_pin_oe(diag_output_pin_oe), .sdo_pad_o(sdo_pad_o), .sdo_pad_oe(sdo_pad_oe),
    .analog_buf_en(analog_buf_en), .sdo_check_active(sdo_check_active));
